// ### shared/ppic_pkg.sv
// Package of constants for the programmable priority interrupt controller
package ppic_pkg;
    localparam int unsigned NUM_LEVELS  = 8;
    localparam int unsigned DATA_W      = 8;
    localparam int unsigned CASC_W      = 3;
    // Register select decode
    localparam logic        SEL_LOW     = 1'b0;
    localparam logic        SEL_HIGH    = 1'b1;
    // Low-address write command codes, bits 7:5
    localparam int unsigned CMD_POS     = 5;
    localparam logic [2:0]  CMD_EOI     = 3'h1;
    localparam logic [2:0]  CMD_SMM_ON  = 3'h2;
    localparam logic [2:0]  CMD_SMM_OFF = 3'h3;
    localparam logic [2:0]  CMD_ROTATE  = 3'h4;
    localparam logic [2:0]  CMD_RD_SERVICE = 3'h5;
    localparam logic [2:0]  CMD_RD_PENDING = 3'h6;
    localparam logic [2:0]  CMD_SET_VEC = 3'h7;
    // Low-address write, bits 2:0 carry a level
    localparam int unsigned LVL_POS     = 0;
    // Reset values
    localparam logic [7:0]  MASK_RST    = 8'hFF;
    localparam logic [7:0]  VEC_RST     = 8'h08;
    localparam logic [2:0]  LOW_PRI_RST = 3'h7;
    typedef enum logic [1:0] { PPIC_READ_PENDING, PPIC_READ_SERVICE } ppic_rdsel_e;
endpackage

// ### src/ppic_prio.sv
// Priority resolver with rotating lowest-priority level
`timescale 1ns/1ps
module ppic_prio #(
    parameter int unsigned N = 8
) (
    input  wire logic [N-1:0]         req,
    input  wire logic [N-1:0]         blk,
    input  wire logic [$clog2(N)-1:0] low_pri,
    output logic                      hit,
    output logic [$clog2(N)-1:0]      lvl
);
    localparam int unsigned LW = $clog2(N);

    if (N < 2)
    begin : g_bad_n
        $error("N must be at least two");
    end

    // Walk from the level just above the lowest, stop at first blocker
    always_comb
    begin
        logic             stop;
        logic [LW-1:0]    idx;
        stop = 1'b0;
        idx  = '0;
        hit  = 1'b0;
        lvl  = '0;
        for (int i = 1; i <= N; i++)
        begin
            idx = LW'((int'(low_pri) + i) % N);
            if (!stop)
            begin
                if (req[idx])
                begin
                    hit  = 1'b1;
                    lvl  = idx;
                    stop = 1'b1;
                end
                else if (blk[idx])
                    stop = 1'b1;
            end
        end
    end
endmodule

// ### src/ppic_core.sv
// Eight-input programmable priority interrupt controller core
// Overview of operation
// - Eight request inputs, software-programmed masking and rotating priority.
// - Pending register records every level requesting service.
// - In-service register records levels whose service is unfinished.
// - Set mask bits keep matching requests out of priority resolution.
// - Special mask mode also masks in-service bits, unblocking lower levels.
// - Resolver picks highest unmasked pending level, passes number onward.
// - Interrupt output raised whenever a resolved request may interrupt.
// - During acknowledge the programmed vector is driven onto the bus.
// - Eight-bit data bus driven only during reads and acknowledges.
// - Register select input chooses which internal register is reached.
// - Chip select and strobes become an internal read level and a write pulse.
// - Separate internal strobes for status reads and command writes.
// - Three cascade lines carry the acknowledged level out when master; cascade input is never decoded.
// - Slave program/enable level chooses cascade master or slave role.
`timescale 1ns/1ps
module ppic_core #(
    parameter int unsigned NUM_LEVELS = ppic_pkg::NUM_LEVELS
) (
    input  wire logic                        clk,
    input  wire logic                        sys_rst,
    input  wire logic                        clk_en,
    input  wire logic [NUM_LEVELS-1:0]       request_inputs,
    input  wire logic                        chip_select_n,
    input  wire logic                        read_strobe_n,
    input  wire logic                        write_strobe_n,
    input  wire logic                        register_select,
    input  wire logic [ppic_pkg::DATA_W-1:0] data_in,
    output logic      [ppic_pkg::DATA_W-1:0] data_out,
    output logic                             data_oe,
    input  wire logic                        acknowledge_n,
    output logic                             irq_out,
    input  wire logic                        slave_program_enable_n,
    input  wire logic [ppic_pkg::CASC_W-1:0] cascade_in,
    output logic      [ppic_pkg::CASC_W-1:0] cascade_out,
    output logic                             cascade_oe
);
    localparam int unsigned LW = $clog2(NUM_LEVELS);

    if (NUM_LEVELS != ppic_pkg::NUM_LEVELS)
    begin : g_bad_levels
        $error("NUM_LEVELS must equal eight");
    end

    logic [7:0]  request_pending_register;
    logic [7:0]  in_service_register;
    logic [7:0]  mask_register;
    logic [7:0]  vector_r;
    logic [2:0]  low_pri_r;
    logic        smm_r;
    logic        rdsel_isr_r;
    logic        wr_d_r;
    logic        ack_d_r;
    logic [7:0]  req_d_r;
    logic [7:0]  dout_r;
    logic [2:0]  ack_lvl_r;

    // Bus strobes and pulses
    wire         rd_lvl     = !chip_select_n && !read_strobe_n;
    wire         wr_lvl     = !chip_select_n && !write_strobe_n;
    wire         wr_pulse   = wr_lvl && !wr_d_r;
    wire         ack_lvl    = !acknowledge_n;
    wire         ack_pulse  = ack_lvl && !ack_d_r;
    // Status read and command write strobes
    wire         status_rd  = rd_lvl && register_select == ppic_pkg::SEL_LOW;
    wire         mask_wr    = wr_pulse && register_select == ppic_pkg::SEL_HIGH;
    wire         cmd_wr     = wr_pulse && register_select == ppic_pkg::SEL_LOW;
    wire [2:0]   cmd_code   = data_in[ppic_pkg::CMD_POS +: 3];
    wire [2:0]   cmd_level  = data_in[ppic_pkg::LVL_POS +: 3];
    wire         master     = slave_program_enable_n;

    // Rising edges of request lines
    wire [7:0]   req_rise   = request_inputs & ~req_d_r;
    // Special mask mode hides masked in-service bits
    wire [7:0]   svc_blk    = smm_r ? (in_service_register & ~mask_register) : in_service_register;
    // Masked requests excluded
    wire [7:0]   req_valid  = request_pending_register & ~mask_register;
    wire         prio_hit;
    wire [2:0]   prio_lvl;
    wire [7:0]   eoi_bit    = 8'h01 << ppic_top_service(in_service_register, low_pri_r);
    // Acknowledge set and end-of-service clear may meet; set wins
    wire [7:0]   ack_bit    = (ack_pulse && prio_hit) ? (8'h01 << prio_lvl) : 8'h00;
    wire [7:0]   eoi_clr    = (cmd_wr && cmd_code == ppic_pkg::CMD_EOI) ? eoi_bit : 8'h00;

    function automatic logic [2:0] ppic_top_service(input logic [7:0] svc, input logic [2:0] low);
        logic [2:0] r;
        logic       f;
        logic [2:0] k;
        r = '0;
        f = 1'b0;
        for (int i = 1; i <= 8; i++)
        begin
            k = 3'((int'(low) + i) % 8);
            if (!f && svc[k])
            begin
                r = k;
                f = 1'b1;
            end
        end
        return r;
    endfunction

    ppic_prio #(
        .N       (8)
    ) u_prio (
        .req     (req_valid),
        .blk     (svc_blk),
        .low_pri (low_pri_r),
        .hit     (prio_hit),
        .lvl     (prio_lvl)
    );

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wr_d_r    <= 1'b0;
            ack_d_r   <= 1'b0;
            req_d_r   <= 8'h00;
            ack_lvl_r <= 3'h0;
        end
        else if (clk_en)
        begin
            wr_d_r  <= wr_lvl;
            ack_d_r <= ack_lvl;
            req_d_r <= request_inputs;
            if (ack_pulse)
                ack_lvl_r <= prio_lvl;
        end
    end

    // Pending: new edge sets, acknowledge clears, set wins
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            request_pending_register <= 8'h00;
        else if (clk_en)
            request_pending_register <= ((request_pending_register & request_inputs) & ~ack_bit) | req_rise;
    end

    // In-service: set on acknowledge, cleared by end-of-service
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            in_service_register <= 8'h00;
        else if (clk_en)
            in_service_register <= (in_service_register & ~eoi_clr) | ack_bit;
    end

    // Mask, vector and priority programming
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            mask_register <= ppic_pkg::MASK_RST;
            vector_r      <= ppic_pkg::VEC_RST;
            low_pri_r     <= ppic_pkg::LOW_PRI_RST;
            smm_r         <= 1'b0;
            rdsel_isr_r   <= 1'b0;
        end
        else if (clk_en)
        begin
            if (mask_wr)
                mask_register <= data_in;
            if (cmd_wr)
            begin
                unique case (cmd_code)
                    ppic_pkg::CMD_SMM_ON:  smm_r <= 1'b1;
                    ppic_pkg::CMD_SMM_OFF: smm_r <= 1'b0;
                    ppic_pkg::CMD_ROTATE:  low_pri_r <= cmd_level;
                    ppic_pkg::CMD_RD_SERVICE: rdsel_isr_r <= 1'b1;
                    ppic_pkg::CMD_RD_PENDING: rdsel_isr_r <= 1'b0;
                    ppic_pkg::CMD_SET_VEC: vector_r <= {data_in[4:0], 3'h0};
                    default: ;
                endcase
            end
        end
    end

    // Read data: vector on acknowledge, else selected register
    wire [7:0] status_val = rdsel_isr_r ? in_service_register : request_pending_register;
    wire [7:0] rd_val     = ack_lvl ? (vector_r | {5'h00, prio_lvl})
                          : status_rd ? status_val : mask_register;

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            dout_r <= 8'h00;
        else if (clk_en)
            dout_r <= ack_pulse ? rd_val : (ack_lvl ? dout_r : rd_val);
    end

    assign data_out    = dout_r;
    assign data_oe     = rd_lvl || ack_lvl;
    assign irq_out     = prio_hit;
    // Master drives acknowledged level on cascade lines
    assign cascade_out = master ? ack_lvl_r : 3'h0;
    assign cascade_oe  = master && ack_lvl;

    // Acknowledge taken with a winning level
    sequence seq_ack_take;
        clk_en && ack_pulse && prio_hit;
    endsequence

    chk_irq_follows_hit: assert property (@(posedge clk) disable iff (sys_rst)
        (|req_valid && svc_blk == 8'h00) |-> irq_out)
        else $error("Interrupt output mismatch");
    chk_oe_idle: assert property (@(posedge clk) disable iff (sys_rst)
        ((chip_select_n || read_strobe_n) && acknowledge_n) |-> !data_oe)
        else $error("Bus driven while idle");
    chk_ack_sets_isr: assert property (@(posedge clk) disable iff (sys_rst)
        seq_ack_take |=> in_service_register[ack_lvl_r])
        else $error("Acknowledge missed in-service");
    chk_ack_vector: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && ack_pulse) |=> data_out == (vector_r | {5'h00, ack_lvl_r}))
        else $error("Wrong vector on acknowledge");
    chk_mask_write: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && mask_wr) |=> mask_register == $past(data_in))
        else $error("Mask write lost");
    chk_masked_no_win: assert property (@(posedge clk) disable iff (sys_rst)
        prio_hit |-> !mask_register[prio_lvl] && request_pending_register[prio_lvl])
        else $error("Masked level won");
    chk_rise_pending: assert property (@(posedge clk) disable iff (sys_rst)
        (clk_en && |req_rise) |=> (request_pending_register & $past(req_rise)) == $past(req_rise))
        else $error("Request edge not recorded");
    chk_smm_unblock: assert property (@(posedge clk) disable iff (sys_rst)
        smm_r |-> (svc_blk & mask_register) == 8'h00)
        else $error("Masked in-service still blocks");
    chk_no_write_pulse: assert property (@(posedge clk) disable iff (sys_rst)
        chip_select_n |-> !mask_wr && !cmd_wr)
        else $error("Write without chip select");
endmodule

// ### sim/ppic_host.sv
// Host bus model: register accesses and interrupt acknowledges
`timescale 1ns/1ps
module ppic_host (
    input  wire logic       clk,
    input  wire logic [7:0] data_out,
    input  wire logic       data_oe,
    input  wire logic [2:0] cascade_out,
    input  wire logic       cascade_oe,
    output logic            chip_select_n,
    output logic            read_strobe_n,
    output logic            write_strobe_n,
    output logic            register_select,
    output logic [7:0]      data_in,
    output logic            acknowledge_n
);
    initial
    begin
        chip_select_n   = 1'b1;
        read_strobe_n   = 1'b1;
        write_strobe_n  = 1'b1;
        register_select = 1'b0;
        data_in         = 8'h00;
        acknowledge_n   = 1'b1;
    end
    // Released data shows the inverse, never a stale copy
    task automatic wr(input logic a, input logic [7:0] d);
        @(posedge clk);
        chip_select_n   <= 1'b0;
        write_strobe_n  <= 1'b0;
        register_select <= a;
        data_in         <= d;
        @(posedge clk);
        chip_select_n   <= 1'b1;
        write_strobe_n  <= 1'b1;
        data_in         <= ~d;
    endtask
    task automatic rd(input logic a, output logic [7:0] q, output logic oe);
        @(posedge clk);
        chip_select_n   <= 1'b0;
        read_strobe_n   <= 1'b0;
        register_select <= a;
        @(negedge clk);
        @(negedge clk);
        q = data_out;
        oe = data_oe;
        @(posedge clk);
        chip_select_n   <= 1'b1;
        read_strobe_n   <= 1'b1;
    endtask
    task automatic ack(output logic [7:0] q, output logic oe, output logic [2:0] co, output logic coe);
        @(posedge clk);
        acknowledge_n <= 1'b0;
        @(negedge clk);
        @(negedge clk);
        q = data_out;
        oe = data_oe;
        co = cascade_out;
        coe = cascade_oe;
        @(posedge clk);
        acknowledge_n <= 1'b1;
    endtask
endmodule

// ### sim/test_programmable_priority_interrupt_ctrl.sv
// Self-checking testbench for the interrupt controller core
`timescale 1ns/1ps
module test_programmable_priority_interrupt_ctrl;
    logic       clk, sys_rst, ce, spe_n, cs_n, rd_n, wr_n, sel, ack_n, oe_w, irq, coe_w, oe, coe;
    logic [7:0] req, din, dout, rv, lfsr, m, r, eff;
    logic [2:0] cin, cout, co, lp, k;
    logic [4:0] base;
    int         fail_count, checks_done;
    ppic_core dut_u (.clk(clk), .sys_rst(sys_rst), .clk_en(ce), .request_inputs(req),
        .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .register_select(sel),
        .data_in(din), .data_out(dout), .data_oe(oe_w), .acknowledge_n(ack_n), .irq_out(irq),
        .slave_program_enable_n(spe_n), .cascade_in(cin), .cascade_out(cout), .cascade_oe(coe_w));
    ppic_host host_u (.clk(clk), .data_out(dout), .data_oe(oe_w), .cascade_out(cout), .cascade_oe(coe_w),
        .chip_select_n(cs_n), .read_strobe_n(rd_n), .write_strobe_n(wr_n), .register_select(sel),
        .data_in(din), .acknowledge_n(ack_n));
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // Highest priority is the level just above the lowest
    function automatic logic [2:0] pick(input logic [7:0] q, input logic [2:0] low);
        logic [2:0] j;
        pick = low;
        for (int i = 8; i >= 1; i--)
        begin
            j = low + 3'(i);
            if (q[j])
                pick = j;
        end
    endfunction
    task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            fail_count++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic irq_chk(input logic e, input string what);
        repeat (2) @(posedge clk);
        #1;
        chk({7'h00, irq}, {7'h00, e}, what);
    endtask
    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial
    begin
        repeat (6000) @(posedge clk);
        fail_count++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        results();
    end
    initial
    begin
        sys_rst = 1'b1;
        ce = 1'b1;
        req = 8'h00;
        cin = 3'h0;
        spe_n = 1'b1;
        lfsr = 8'h37;
        repeat (20) @(posedge clk);
        sys_rst <= 1'b0;
        host_u.rd(1'b1, rv, oe);
        chk(rv, 8'hFF, "mask reset");
        chk({7'h00, oe}, 8'h01, "oe on read");
        @(negedge clk);
        chk({7'h00, oe_w}, 8'h00, "oe idle");
        @(posedge clk);
        $display("test reset done");
        for (int n = 0; n < 12; n++)
        begin
            lfsr = lfsr_next(lfsr);
            m = lfsr;
            lfsr = lfsr_next(lfsr);
            r = lfsr;
            eff = r & ~m;
            lp = m[2:0] ^ r[5:3];
            base = r[4:0] ^ m[7:3];
            cin <= r[2:0];
            host_u.wr(1'b1, m);
            host_u.wr(1'b0, {ppic_pkg::CMD_ROTATE, 2'b00, lp});
            host_u.wr(1'b0, {ppic_pkg::CMD_SET_VEC, base});
            host_u.wr(1'b0, {ppic_pkg::CMD_RD_PENDING, 5'h00});
            req <= r;
            irq_chk(|eff, "irq level");
            host_u.rd(1'b1, rv, oe);
            chk(rv, m, "mask read");
            host_u.rd(1'b0, rv, oe);
            chk(rv, r, "pending read");
            if (eff != 8'h00)
            begin
                k = pick(eff, lp);
                host_u.ack(rv, oe, co, coe);
                chk(rv, {base, k}, "vector");
                chk({4'h0, coe, co}, {4'h0, 1'b1, k}, "cascade");
                host_u.wr(1'b0, {ppic_pkg::CMD_RD_SERVICE, 5'h00});
                host_u.rd(1'b0, rv, oe);
                chk(rv, 8'h01 << k, "in service");
                host_u.wr(1'b0, {ppic_pkg::CMD_EOI, 5'h00});
                host_u.rd(1'b0, rv, oe);
                chk(rv, 8'h00, "service end");
            end
            req <= 8'h00;
        end
        $display("test random done");
        host_u.wr(1'b1, 8'h00);
        host_u.wr(1'b0, {ppic_pkg::CMD_ROTATE, 5'h07});
        req <= 8'h02;
        host_u.ack(rv, oe, co, coe);
        req <= 8'h42;
        irq_chk(1'b0, "blocked by service");
        host_u.wr(1'b1, 8'h02);
        host_u.wr(1'b0, {ppic_pkg::CMD_SMM_ON, 5'h00});
        irq_chk(1'b1, "special mask on");
        host_u.wr(1'b0, {ppic_pkg::CMD_SMM_OFF, 5'h00});
        irq_chk(1'b0, "special mask off");
        host_u.wr(1'b0, {ppic_pkg::CMD_SMM_ON, 5'h00});
        spe_n <= 1'b0;
        host_u.ack(rv, oe, co, coe);
        chk(rv, {base, 3'h6}, "slave vector");
        chk({6'h00, oe, coe}, 8'h02, "slave drive");
        $display("test special mask done");
        ce <= 1'b0;
        host_u.wr(1'b1, 8'h5A);
        ce <= 1'b1;
        host_u.rd(1'b1, rv, oe);
        chk(rv, 8'h02, "frozen mask write");
        $display("test clock enable done");
        results();
    end
endmodule
